// file: design/digital_io_port_control.sv
// Four-pin bidirectional port with AXI4-Lite register access
`timescale 1ns/100ps
`include "gpio_port_defines.svh"

// Overview of operation
// - Threshold bits choose Schmitt or TTL input
// - Direction one disables the pin driver
// - Direction zero drives latch value onto pin
// - Port reads give pins, writes go latch
// - Port writes sample pins, modify, store latch
// - Driver gating ignores analog selection
// - Analog pins read zero, analog path enabled
// - Open-drain bit makes pin sink only
// - Slew bit asserts slew-limited drive
// - Analog select never affects digital output
// - Analog select resets to analog mode
// - Pin output defaults to port latch
// - Analog inputs active only in analog mode
// - Pull-ups need global disable bit cleared
// - Pull-up off whenever pin is output
module digital_io_port_control (
	input  wire logic        sys_clk,          // Core clock, 125 MHz
	input  wire logic        reset,            // Synchronous reset, high
	input  wire logic [7:0]  s_axi_awaddr,     // Write address
	input  wire logic        s_axi_awvalid,    // Write address valid
	output logic             s_axi_awready,    // Write address ready
	input  wire logic [31:0] s_axi_wdata,      // Write data
	input  wire logic [3:0]  s_axi_wstrb,      // Write byte strobes
	input  wire logic        s_axi_wvalid,     // Write data valid
	output logic             s_axi_wready,     // Write data ready
	output logic [1:0]       s_axi_bresp,      // Write response
	output logic             s_axi_bvalid,     // Write response valid
	input  wire logic        s_axi_bready,     // Write response ready
	input  wire logic [7:0]  s_axi_araddr,     // Read address
	input  wire logic        s_axi_arvalid,    // Read address valid
	output logic             s_axi_arready,    // Read address ready
	output logic [31:0]      s_axi_rdata,      // Read data
	output logic [1:0]       s_axi_rresp,      // Read response
	output logic             s_axi_rvalid,     // Read data valid
	input  wire logic        s_axi_rready,     // Read data ready
	input  wire logic [3:0]  pinInSchmitt,     // Pin level, Schmitt buffer
	input  wire logic [3:0]  pinInTtl,         // Pin level, TTL buffer
	output logic [3:0]       pinOut,           // Pin output level
	output logic [3:0]       pinOutEnable_n,   // Driver enable, low drives
	output logic [3:0]       slewLimitControl, // High limits slew rate
	output logic [3:0]       schmittThreshold, // High selects Schmitt
	output logic [3:0]       weakPullupOn,     // Pull-up device on
	output logic [3:0]       analogPathEnable, // Analog input connected
	output logic [3:0]       digitalIn         // Masked input to peripherals
);

	// Software visible state
	gpio_port_pkg::reg8_t outputLatch;         // Port output latch
	gpio_port_pkg::reg8_t directionBits;       // One means input
	gpio_port_pkg::reg8_t analogSelect;        // One means analog mode
	gpio_port_pkg::reg8_t openDrainEnable;     // One means sink only
	gpio_port_pkg::reg8_t slewLimit;           // One means limited slew
	gpio_port_pkg::reg8_t thresholdSelect;     // One means Schmitt
	gpio_port_pkg::reg8_t weakPullupEnable;    // Per-pin pull-up request
	gpio_port_pkg::reg8_t optionControl;       // Global option bits
	gpio_port_pkg::reg8_t next_outputLatch;
	gpio_port_pkg::reg8_t next_directionBits;
	gpio_port_pkg::reg8_t next_analogSelect;
	gpio_port_pkg::reg8_t next_openDrainEnable;
	gpio_port_pkg::reg8_t next_slewLimit;
	gpio_port_pkg::reg8_t next_thresholdSelect;
	gpio_port_pkg::reg8_t next_weakPullupEnable;
	gpio_port_pkg::reg8_t next_optionControl;

	// Synchronisers and derived pin view
	logic [3:0]           schmittMeta;         // First stage, Schmitt
	logic [3:0]           schmittSync;         // Second stage, Schmitt
	logic [3:0]           ttlMeta;             // First stage, TTL
	logic [3:0]           ttlSync;             // Second stage, TTL
	gpio_port_pkg::reg8_t pinView;             // Pin levels as read

	// Write channel state
	logic                 awHeld;              // Address captured
	logic                 wHeld;               // Data captured
	logic [7:0]           awAddr;              // Captured address
	logic [7:0]           wData;               // Captured low byte
	logic                 wLane0;              // Captured lane 0 strobe
	logic                 bValid;              // Response pending
	logic [1:0]           bResp;               // Response code
	logic                 next_awHeld;
	logic                 next_wHeld;
	logic [7:0]           next_awAddr;
	logic [7:0]           next_wData;
	logic                 next_wLane0;
	logic                 next_bValid;
	logic [1:0]           next_bResp;
	logic                 doWrite;             // Both halves present

	// Read channel state
	logic                 rValid;              // Read data pending
	logic [7:0]           rData;               // Read data byte
	logic [1:0]           rResp;               // Read response code
	logic                 next_rValid;
	logic [7:0]           next_rData;
	logic [1:0]           next_rResp;

	// Two-stage synchronisers; the first stage feeds nothing else
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			schmittMeta <= 4'h0;
			schmittSync <= 4'h0;
			ttlMeta     <= 4'h0;
			ttlSync     <= 4'h0;
		end else begin
			schmittMeta <= pinInSchmitt;
			schmittSync <= schmittMeta;
			ttlMeta     <= pinInTtl;
			ttlSync     <= ttlMeta;
		end
	end

	// Per-pin input selection, masking and driver control
	generate
		for (genvar i = 0; i < `PIN_COUNT; i++) begin : g_pin
			localparam int B = i + `PIN_LSB;
			logic level;                                         // Chosen buffer
			assign level = thresholdSelect[B] ? schmittSync[i]
			                                  : ttlSync[i];
			// Analog pins read zero everywhere digital
			assign pinView[B]   = level & ~analogSelect[B];
			assign digitalIn[i] = pinView[B];
			assign pinView[B-`PIN_LSB] = 1'b0;
			// Open drain only ever pulls low
			assign pinOut[i] = outputLatch[B] & ~openDrainEnable[B];
			// Driver gated by direction and by open drain with latch high, never by analog select
			assign pinOutEnable_n[i] = directionBits[B]
				| (openDrainEnable[B] & outputLatch[B]);
			assign slewLimitControl[i] = slewLimit[B];
			assign schmittThreshold[i] = thresholdSelect[B];
			// Pull-up only for inputs with the global disable clear
			assign weakPullupOn[i] = weakPullupEnable[B]
				& ~optionControl[`OPT_PULLUP_DIS_BIT]
				& directionBits[B];
			assign analogPathEnable[i] = analogSelect[B];
		end
	endgenerate

	// Handshake outputs
	assign s_axi_awready = ~awHeld & ~bValid;
	assign s_axi_wready  = ~wHeld & ~bValid;
	assign s_axi_bvalid  = bValid;
	assign s_axi_bresp   = bResp;
	assign s_axi_arready = ~rValid;
	assign s_axi_rvalid  = rValid;
	assign s_axi_rresp   = rResp;
	assign s_axi_rdata   = {24'h000000, rData};
	assign doWrite       = awHeld & wHeld & ~bValid;

	// Write channel: capture halves in either order, then commit
	always_comb begin
		next_awHeld = awHeld;
		next_wHeld  = wHeld;
		next_awAddr = awAddr;
		next_wData  = wData;
		next_wLane0 = wLane0;
		next_bValid = bValid;
		next_bResp  = bResp;
		if (s_axi_awvalid && s_axi_awready) begin
			next_awHeld = 1'b1;
			next_awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_wHeld  = 1'b1;
			next_wData  = s_axi_wdata[7:0];
			next_wLane0 = s_axi_wstrb[0];
		end
		if (doWrite) begin
			next_awHeld = 1'b0;
			next_wHeld  = 1'b0;
			next_bValid = 1'b1;
			case (awAddr)
				`OFS_PIN_VALUE, `OFS_OUTPUT_LATCH, `OFS_DIRECTION,
				`OFS_ANALOG_SELECT, `OFS_OPEN_DRAIN, `OFS_SLEW_LIMIT,
				`OFS_THRESHOLD, `OFS_WEAK_PULLUP, `OFS_OPTION: begin
					next_bResp = gpio_port_pkg::RESP_OKAY;
				end
				default: begin
					next_bResp = gpio_port_pkg::RESP_SLVERR; // Unmapped
				end
			endcase
		end else if (bValid && s_axi_bready) begin
			next_bValid = 1'b0;
		end
	end

	// Register file updates on a committed write
	always_comb begin
		next_outputLatch      = outputLatch;
		next_directionBits    = directionBits;
		next_analogSelect     = analogSelect;
		next_openDrainEnable  = openDrainEnable;
		next_slewLimit        = slewLimit;
		next_thresholdSelect  = thresholdSelect;
		next_weakPullupEnable = weakPullupEnable;
		next_optionControl    = optionControl;
		if (doWrite) begin
			case (awAddr)
				// Port write: sampled pins, modified by the written lane
				`OFS_PIN_VALUE: begin
					next_outputLatch = (wLane0 ? wData : pinView)
						& `MASK_PORT;
				end
				`OFS_OUTPUT_LATCH: begin
					if (wLane0) next_outputLatch = wData & `MASK_PORT;
				end
				`OFS_DIRECTION: begin
					if (wLane0) next_directionBits = wData & `MASK_PORT;
				end
				`OFS_ANALOG_SELECT: begin
					if (wLane0) next_analogSelect = wData & `MASK_ANALOG;
				end
				`OFS_OPEN_DRAIN: begin
					if (wLane0) next_openDrainEnable = wData & `MASK_PORT;
				end
				`OFS_SLEW_LIMIT: begin
					if (wLane0) next_slewLimit = wData & `MASK_PORT;
				end
				`OFS_THRESHOLD: begin
					if (wLane0) next_thresholdSelect = wData
						& `MASK_THRESHOLD;
				end
				`OFS_WEAK_PULLUP: begin
					if (wLane0) next_weakPullupEnable = wData & `MASK_PORT;
				end
				`OFS_OPTION: begin
					if (wLane0) next_optionControl = wData & `MASK_OPTION;
				end
				default: begin
					next_optionControl = optionControl;      // No effect
				end
			endcase
		end
	end

	// Read channel: one cycle from address to data
	always_comb begin
		next_rValid = rValid;
		next_rData  = rData;
		next_rResp  = rResp;
		if (s_axi_arvalid && s_axi_arready) begin
			next_rValid = 1'b1;
			next_rResp  = gpio_port_pkg::RESP_OKAY;
			case (s_axi_araddr)
				`OFS_PIN_VALUE:     next_rData = pinView;
				`OFS_OUTPUT_LATCH:  next_rData = outputLatch;
				`OFS_DIRECTION:     next_rData = directionBits;
				`OFS_ANALOG_SELECT: next_rData = analogSelect;
				`OFS_OPEN_DRAIN:    next_rData = openDrainEnable;
				`OFS_SLEW_LIMIT:    next_rData = slewLimit;
				`OFS_THRESHOLD:     next_rData = thresholdSelect;
				`OFS_WEAK_PULLUP:   next_rData = weakPullupEnable;
				`OFS_OPTION:        next_rData = optionControl;
				default: begin
					next_rData = 8'h00;                          // Unmapped
					next_rResp = gpio_port_pkg::RESP_SLVERR;
				end
			endcase
		end else if (rValid && s_axi_rready) begin
			next_rValid = 1'b0;
		end
	end

	// State registers; analog select comes up in analog mode
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			outputLatch      <= `RST_LATCH;
			directionBits    <= `RST_DIRECTION;
			analogSelect     <= `RST_ANALOG;
			openDrainEnable  <= `RST_OPEN_DRAIN;
			slewLimit        <= `RST_SLEW_LIMIT;
			thresholdSelect  <= `RST_THRESHOLD;
			weakPullupEnable <= `RST_WEAK_PULLUP;
			optionControl    <= `RST_OPTION;
			awHeld           <= 1'b0;
			wHeld            <= 1'b0;
			awAddr           <= 8'h00;
			wData            <= 8'h00;
			wLane0           <= 1'b0;
			bValid           <= 1'b0;
			bResp            <= 2'b00;
			rValid           <= 1'b0;
			rData            <= 8'h00;
			rResp            <= 2'b00;
		end else begin
			outputLatch      <= next_outputLatch;
			directionBits    <= next_directionBits;
			analogSelect     <= next_analogSelect;
			openDrainEnable  <= next_openDrainEnable;
			slewLimit        <= next_slewLimit;
			thresholdSelect  <= next_thresholdSelect;
			weakPullupEnable <= next_weakPullupEnable;
			optionControl    <= next_optionControl;
			awHeld           <= next_awHeld;
			wHeld            <= next_wHeld;
			awAddr           <= next_awAddr;
			wData            <= next_wData;
			wLane0           <= next_wLane0;
			bValid           <= next_bValid;
			bResp            <= next_bResp;
			rValid           <= next_rValid;
			rData            <= next_rData;
			rResp            <= next_rResp;
		end
	end

endmodule // digital_io_port_control

// file: design/gpio_port_defines.svh
// Register offsets, field positions, masks and reset values of the port
`ifndef GPIO_PORT_DEFINES_SVH
`define GPIO_PORT_DEFINES_SVH

// Byte addresses on the register bus
`define OFS_PIN_VALUE      8'h00
`define OFS_OUTPUT_LATCH   8'h04
`define OFS_DIRECTION      8'h08
`define OFS_ANALOG_SELECT  8'h0C
`define OFS_OPEN_DRAIN     8'h10
`define OFS_SLEW_LIMIT     8'h14
`define OFS_THRESHOLD      8'h18
`define OFS_WEAK_PULLUP    8'h1C
`define OFS_OPTION         8'h20

// Pin field: the four pins occupy bits 7 to 4
`define PIN_LSB            4
`define PIN_COUNT          4

// Implemented bits per register, others read zero
`define MASK_PORT          8'hF0
`define MASK_ANALOG        8'h30
`define MASK_THRESHOLD     8'h3F
`define MASK_OPTION        8'hFF

// Global pull-up disable in the option register
`define OPT_PULLUP_DIS_BIT 7

// Reset values
`define RST_LATCH          8'h00
`define RST_DIRECTION      8'hF0
`define RST_ANALOG         8'h30
`define RST_OPEN_DRAIN     8'h00
`define RST_SLEW_LIMIT     8'hF0
`define RST_THRESHOLD      8'h00
`define RST_WEAK_PULLUP    8'hF0
`define RST_OPTION         8'hFF

`endif

// file: design/gpio_port_pkg.sv
// Types shared by the port control logic
package gpio_port_pkg;

	// One 8-bit port register
	typedef logic [7:0] reg8_t;

	// Bus response codes
	typedef enum logic [1:0] {
		RESP_OKAY   = 2'b00,
		RESP_SLVERR = 2'b10
	} resp_e;

endpackage

// file: verif/pin_partner.sv
// Model of the four package pins around the port
`timescale 1ns/100ps
module pin_partner (
	input  wire logic       sys_clk,        // Core clock
	input  wire logic [3:0] pinOut,         // Level from port
	input  wire logic [3:0] pinOutEnable_n, // Low while port drives
	input  wire logic [3:0] weakPullupOn,   // Pull-up device on
	input  wire logic [3:0] extVal,         // Outside driver level
	input  wire logic [3:0] extEn,          // Outside driver on
	input  wire logic       ttlFlip,        // TTL buffer reads opposite
	output logic      [3:0] pinInSchmitt,   // Schmitt buffer view
	output logic      [3:0] pinInTtl        // TTL buffer view
);
	logic [3:0] floatLvl = 4'h5; // Undriven level, wanders
	logic [3:0] pinLvl;          // Resolved wire level
	// Toggle so a released pin never keeps a stale value
	always @(posedge sys_clk) begin
		floatLvl <= ~floatLvl;
	end
	// Port driver wins, then outside driver, pull-up, float
	assign pinLvl = (~pinOutEnable_n & pinOut) | (pinOutEnable_n &
		((extEn & extVal) | (~extEn & (weakPullupOn | floatLvl))));
	assign pinInSchmitt = pinLvl;
	// Commanded skew lets the bench tell the buffers apart
	assign pinInTtl = pinLvl ^ {4{ttlFlip}};
endmodule // pin_partner

// file: verif/digital_io_port_control_checker.sv
// Concurrent checks on the port control block's ports
`timescale 1ns/100ps
module digital_io_port_control_checker (
	input wire logic        sys_clk,          // Core clock
	input wire logic        reset,            // Sync reset
	input wire logic        s_axi_awvalid,    // AW valid
	input wire logic        s_axi_awready,    // AW ready
	input wire logic        s_axi_wvalid,     // W valid
	input wire logic        s_axi_wready,     // W ready
	input wire logic [1:0]  s_axi_bresp,      // B code
	input wire logic        s_axi_bvalid,     // B valid
	input wire logic        s_axi_bready,     // B ready
	input wire logic        s_axi_arvalid,    // AR valid
	input wire logic        s_axi_arready,    // AR ready
	input wire logic [31:0] s_axi_rdata,      // R data
	input wire logic        s_axi_rvalid,     // R valid
	input wire logic [3:0]  pinInSchmitt,     // Schmitt view
	input wire logic [3:0]  pinInTtl,         // TTL view
	input wire logic [3:0]  pinOutEnable_n,   // Low drives
	input wire logic [3:0]  schmittThreshold, // Buffer choice
	input wire logic [3:0]  weakPullupOn,     // Pull-up on
	input wire logic [3:0]  analogPathEnable, // Analog mode
	input wire logic [3:0]  digitalIn         // Masked input
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	// Both write halves taken on one edge
	sequence s_wtake;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// Two clean edges since reset, so both sync stages hold pin data
	sequence s_run;
		!$past(reset, 2) && !$past(reset);
	endsequence
	property p_wresp; s_wtake |-> ##[1:2] s_axi_bvalid; endproperty
	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	property p_rdy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	property p_rhigh; s_axi_rvalid |-> !s_axi_arready &&
		s_axi_rdata[31:8] == 24'h000000; endproperty
	property p_ana;
		(digitalIn & analogPathEnable & $past(analogPathEnable)) == 4'h0;
	endproperty
	property p_pull; (weakPullupOn & ~pinOutEnable_n) == 4'h0; endproperty
	// Selected buffer two edges back, masked by analog mode
	property p_sync; s_run |-> digitalIn == (~analogPathEnable &
		((schmittThreshold & $past(pinInSchmitt, 2)) |
		(~schmittThreshold & $past(pinInTtl, 2)))); endproperty
	property p_rstdrv; $fell(reset) |-> pinOutEnable_n == 4'hF &&
		analogPathEnable == 4'h3; endproperty
	a_wresp: assert property (p_wresp) else $error("late write reply");
	a_bhold: assert property (p_bhold) else $error("write reply dropped");
	a_rdy: assert property (p_rdy) else $error("ready while replying");
	a_rlat: assert property (p_rlat) else $error("late read reply");
	a_rhigh: assert property (p_rhigh) else $error("bad read word");
	a_ana: assert property (p_ana) else $error("analog pin reads one");
	a_pull: assert property (p_pull) else $error("pull-up on output");
	a_sync: assert property (p_sync) else $error("input path wrong");
	a_rstdrv: assert property (p_rstdrv) else $error("reset pin state");
endmodule // digital_io_port_control_checker

// file: verif/digital_io_port_control_tb.sv
// Self-checking bench for the port control block
`timescale 1ns/100ps
module digital_io_port_control_tb;
	logic        sys_clk = 1'b0;                          // Core clock
	logic        reset = 1'b1;                            // Sync reset
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00; // Addresses
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;        // Data
	logic [3:0]  s_axi_wstrb = 4'h0;                      // Strobes
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0; // Valids
	logic        s_axi_arvalid = 1'b0, s_axi_bready = 1'b0; // Requests
	logic        s_axi_rready = 1'b0;                     // Read ready
	logic        s_axi_awready, s_axi_wready, s_axi_arready; // Readies
	logic        s_axi_bvalid, s_axi_rvalid;              // Replies
	logic [1:0]  s_axi_bresp, s_axi_rresp, wResp, rResp;  // Codes
	logic [3:0]  pinInSchmitt, pinInTtl, pinOut, pinOutEnable_n; // Pins
	logic [3:0]  slewLimitControl, schmittThreshold, weakPullupOn; // Pads
	logic [3:0]  analogPathEnable, digitalIn;             // Inputs out
	logic [3:0]  extVal = 4'h0, extEn = 4'h0;             // Outside drive
	logic        ttlFlip = 1'b0;                          // Buffer skew
	logic [31:0] rd32;                                    // Last read
	int          errors = 0, cmpCount = 0;                // Tallies
	// Row: address, reset value, write value, read-back value
	logic [31:0] rows [9] = '{32'h04_00_FF_F0, 32'h08_F0_0F_00,
		32'h0C_30_FF_30, 32'h10_00_5A_50, 32'h14_F0_A5_A0,
		32'h18_00_FF_3F, 32'h1C_F0_3C_30, 32'h20_FF_7E_7E,
		32'h24_00_55_00};
	digital_io_port_control u_dut (.sys_clk, .reset, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.pinInSchmitt, .pinInTtl, .pinOut, .pinOutEnable_n,
		.slewLimitControl, .schmittThreshold, .weakPullupOn,
		.analogPathEnable, .digitalIn);
	pin_partner u_pins (.sys_clk, .pinOut, .pinOutEnable_n, .weakPullupOn,
		.extVal, .extEn, .ttlFlip, .pinInSchmitt, .pinInTtl);
	// Half period of 4 ns gives 125 MHz
	always #4 sys_clk = ~sys_clk;
	// One comparison, counted
	task automatic chk(input string n, input logic [31:0] e, v);
		cmpCount++;
		if (v !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", n, e, v);
		end
	endtask
	// Write: both halves offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, d, input logic [3:0] s);
		logic ta, tw;
		ta = 1'b0;
		tw = 1'b0;
		// Start on a rising edge, never in the step of a release
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= 32'(d);
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(ta && tw)) begin
			@(posedge sys_clk);
			if (s_axi_awready && !ta) begin
				ta = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready && !tw) begin
				tw = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		// Late ready makes the response wait and hold for a cycle
		do @(posedge sys_clk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b1;
		@(posedge sys_clk);
		wResp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	// Read: hold the address until taken, then wait for data
	task automatic rd(input logic [7:0] a);
		// Start on a rising edge, never in the step of a release
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge sys_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge sys_clk); while (!s_axi_rvalid);
		rd32 = s_axi_rdata;
		rResp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// Single exit for normal end and watchdog
	task automatic print_verdict();
		$display("errors %0d of %0d comparisons", errors, cmpCount);
		if (errors == 0 && cmpCount > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Watchdog, far beyond the few hundred cycles needed
	initial begin
		repeat (5000) @(posedge sys_clk);
		errors++;
		print_verdict();
	end
	initial begin
		repeat (16) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		// Reset value, write, read back; unmapped slot answers error
		for (int i = 0; i < 9; i++) begin
			rd(rows[i][31:24]);
			chk("reset value", 32'(rows[i][23:16]), rd32);
			wr(rows[i][31:24], rows[i][15:8], 4'h1);
			chk("bresp", (rows[i][31:24] == 8'h24) ? 2 : 0, 32'(wResp));
			rd(rows[i][31:24]);
			chk("read back", 32'(rows[i][7:0]), rd32);
			chk("rresp", (rows[i][31:24] == 8'h24) ? 2 : 0, 32'(rResp));
		end
		@(negedge sys_clk);
		chk("pads", 32'h00A5A303, 32'({pinOut, pinOutEnable_n,
			slewLimitControl, schmittThreshold, weakPullupOn,
			analogPathEnable}));
		wr(8'h08, 8'hF0, 4'h1);
		@(negedge sys_clk);
		chk("inputs", 32'h000000F3, 32'({pinOutEnable_n, weakPullupOn}));
		wr(8'h20, 8'h80, 4'h1);
		@(negedge sys_clk);
		chk("pull-up off", 32'h0, 32'(weakPullupOn));
		// Outside drive 0110; TTL buffer sees it inverted
		@(posedge sys_clk);
		extEn <= 4'hF;
		extVal <= 4'h6;
		ttlFlip <= 1'b1;
		wr(8'h0C, 8'h00, 4'h1);
		repeat (3) @(posedge sys_clk);
		rd(8'h00);
		chk("pin view", 32'h000000A0, rd32);
		wr(8'h0C, 8'h30, 4'h1);
		rd(8'h00);
		chk("analog view", 32'h00000080, rd32);
		@(negedge sys_clk);
		chk("digital in", 32'h8, 32'(digitalIn));
		// Strobe off: latch takes the sampled pin view
		wr(8'h00, 8'h00, 4'h0);
		rd(8'h04);
		chk("rmw latch", 32'h00000080, rd32);
		wr(8'h00, 8'h50, 4'h1);
		rd(8'h04);
		chk("latch", 32'h00000050, rd32);
		rd(8'h00);
		chk("pins kept", 32'h00000080, rd32);
		// Outputs on analog pins still driven from the latch
		extEn <= 4'h0;
		wr(8'h10, 8'h00, 4'h1);
		wr(8'h08, 8'h00, 4'h1);
		@(negedge sys_clk);
		chk("drive", 32'h503, 32'({pinOut, pinOutEnable_n,
			analogPathEnable}));
		// Second reset mid-run
		@(posedge sys_clk);
		reset <= 1'b1;
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		@(negedge sys_clk);
		chk("after reset", 32'h000FF003, 32'({pinOut, pinOutEnable_n,
			slewLimitControl, schmittThreshold, weakPullupOn,
			analogPathEnable}));
		print_verdict();
	end
endmodule // digital_io_port_control_tb
bind digital_io_port_control digital_io_port_control_checker u_chk (
	.sys_clk, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.pinInSchmitt, .pinInTtl, .pinOutEnable_n, .schmittThreshold,
	.weakPullupOn, .analogPathEnable, .digitalIn);
